// ===== aps_ctrl.v
// Post-loop-oscillator divider control and distribution sync for
// output channels A and B of output analog loop zero.
// Assumes a byte register port on core_clk and pin-level status
// inputs from the analog loop, digital loop and reference path.
//
// Function
// - Four-bit divide code maps directly to ratio for codes 2 to 11 except 4; all others undefined, reset 0.
// - Source select clear: sync gated only by calibration done and lock.
// - Source select set: sync waits for next active reference edge.
// - Auto sync: 00 off, 01 on frequency lock, 10 on phase lock, 11 reserved.
// - Mask clear: sync withheld until calibrated and locked, then armed.
// - Mask set: lock state ignored, sync control settings govern.
// - Channel B mask set releases B divider and ignores all sync.
// - Channel A mask set releases A divider and ignores all sync.
// - Channel masks never enable output drivers.
// - Divider reset bit one holds post divider in reset.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
`include "aps_regs.vh"

module aps_ctrl (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Register port
    input wire [11:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Loop status pins
    input wire loop_cal_done,
    input wire loop_locked,
    input wire digital_tracking_loop_freq_lock,
    input wire digital_tracking_loop_phase_lock,
    // Active reference clock pin and external sync request pin
    input wire active_ref,
    input wire ext_sync_req,
    // Post divider control
    output reg [3:0] post_vco_divider_ratio,
    output reg post_vco_divider_ratio_valid,
    output reg post_vco_divider_reset,
    output reg loop_filter_bypass,
    // Channel divider control
    output reg output_channel_a_hold,
    output reg output_channel_a_start,
    output reg output_channel_b_hold,
    output reg output_channel_b_start,
    // Sync state
    output reg sync_armed
);

// ----------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------
reg [1:0] div_reset_ctl;
reg [3:0] divide_code;
reg [2:0] sync_control;
reg [2:0] sync_masks;
reg sw_sync;
reg [7:0] sync_count;
reg sync_pending;
reg sync_pulse;
reg ref_prev;
reg freq_prev;
reg phase_prev;
reg ext_prev;
reg [7:0] next_rdata;
wire [5:0] pins_sync;
wire cal_done_s;
wire locked_s;
wire freq_s;
wire phase_s;
wire ref_s;
wire ext_s;
wire armed;
wire auto_event;
wire ext_event;
wire ref_edge;
wire sync_request;
wire sync_fire;
wire hold_a;
wire hold_b;
wire start_a;
wire start_b;
wire wr_div_reset;
wire wr_divide;
wire wr_control;
wire wr_masks;
wire wr_command;

// ----------------------------------------------------------------
// Functions
// ----------------------------------------------------------------
// Divide code to ratio; zero marks an undefined code
function [3:0] aps_div_ratio;
    input [3:0] code;
    begin
        if (code >= `APS_DIV_CODE_TWO && code <= `APS_DIV_CODE_MAX && code != `APS_DIV_CODE_FOUR) begin
            aps_div_ratio = code;
        end else begin
            aps_div_ratio = 4'h0;
        end
    end
endfunction

// Register write decode, shared by every writable register
function aps_hit;
    input [11:0] addr;
    input [11:0] ofs;
    begin
        aps_hit = (addr == ofs);
    end
endfunction

// ----------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------
// All status pins come from other domains, so two flops each
aps_sync2 #(
    .WIDTH(6)
) u_pins (
    .core_clk(core_clk),
    .rst(rst),
    .async_in({ext_sync_req, active_ref, digital_tracking_loop_phase_lock, digital_tracking_loop_freq_lock, loop_locked, loop_cal_done}),
    .sync_out(pins_sync)
);

assign cal_done_s = pins_sync[0];
assign locked_s = pins_sync[1];
assign freq_s = pins_sync[2];
assign phase_s = pins_sync[3];
assign ref_s = pins_sync[4];
assign ext_s = pins_sync[5];

// ----------------------------------------------------------------
// Register write decode
// ----------------------------------------------------------------
assign wr_div_reset = reg_wr & aps_hit(reg_addr, `APS_OFS_DIV_RESET_CTL);
assign wr_divide = reg_wr & aps_hit(reg_addr, `APS_OFS_POST_VCO_DIVIDE_RATIO);
assign wr_control = reg_wr & aps_hit(reg_addr, `APS_OFS_DISTRIBUTION_SYNC_CONTROL);
assign wr_masks = reg_wr & aps_hit(reg_addr, `APS_OFS_DISTRIBUTION_SYNC_MASKS);
assign wr_command = reg_wr & aps_hit(reg_addr, `APS_OFS_SYNC_COMMAND);

// ----------------------------------------------------------------
// Configuration registers
// ----------------------------------------------------------------
// Divide-by-two legality and reprogramming order are left to
// software; the block stores whatever code is written
always @(posedge core_clk) begin
    if (rst) begin
        div_reset_ctl <= `APS_RST_DIV_RESET_CTL;
        divide_code <= `APS_RST_DIVIDE_CODE;
        sync_control <= `APS_RST_SYNC_CONTROL;
        sync_masks <= `APS_RST_SYNC_MASKS;
    end else begin
        if (wr_div_reset) begin
            div_reset_ctl <= reg_wdata[1:0];
        end
        if (wr_divide) begin
            divide_code <= reg_wdata[3:0];
        end
        if (wr_control) begin
            sync_control <= reg_wdata[2:0];
        end
        if (wr_masks) begin
            sync_masks <= reg_wdata[2:0];
        end
    end
end

// Software sync command, one-cycle self-clearing strobe
always @(posedge core_clk) begin
    if (rst) begin
        sw_sync <= 1'b0;
    end else begin
        sw_sync <= wr_command & reg_wdata[`APS_BIT_SW_SYNC];
    end
end

// ----------------------------------------------------------------
// Arming and event detection
// ----------------------------------------------------------------
// Loop mask overrides the lock detector, else wait for cal and lock
assign armed = sync_control[`APS_BIT_SRC_SEL] ? (sync_masks[`APS_BIT_MASK_LOOP] | (cal_done_s & locked_s))
    : (sync_masks[`APS_BIT_MASK_LOOP] | (cal_done_s & locked_s));

// History of synchronised levels for edge detection
// Reset level equals the idle pin level, so no false edge
always @(posedge core_clk) begin
    if (rst) begin
        ref_prev <= 1'b0;
        freq_prev <= 1'b0;
        phase_prev <= 1'b0;
        ext_prev <= 1'b0;
    end else begin
        ref_prev <= ref_s;
        freq_prev <= freq_s;
        phase_prev <= phase_s;
        ext_prev <= ext_s;
    end
end

// Auto sync on lock acquisition; reserved code does nothing
assign auto_event = (sync_control[1:0] == `APS_AUTO_FREQ) ? (freq_s & ~freq_prev) :
    (sync_control[1:0] == `APS_AUTO_PHASE) ? (phase_s & ~phase_prev) : 1'b0;
assign ext_event = ext_s & ~ext_prev;
// Arming adds no request of its own; the sync left pending by
// reset is what fires on the first arming
assign ref_edge = ref_s & ~ref_prev;
assign sync_request = auto_event | ext_event | sw_sync;

// Pending request fires when armed; reference mode also waits
// for the next active reference edge
assign sync_fire = sync_pending & armed & (~sync_control[`APS_BIT_SRC_SEL] | ref_edge);

// ----------------------------------------------------------------
// Sync pending flag and pulse
// ----------------------------------------------------------------
// A request made before arming is withheld, not lost; a new
// request in the firing cycle wins over the clear
always @(posedge core_clk) begin
    if (rst) begin
        sync_pending <= 1'b1;
        sync_pulse <= 1'b0;
    end else begin
        if (sync_request) begin
            sync_pending <= 1'b1;
        end else if (sync_fire) begin
            sync_pending <= 1'b0;
        end
        sync_pulse <= sync_fire;
    end
end

// Count of issued sync pulses, wraps, for software visibility
always @(posedge core_clk) begin
    if (rst) begin
        sync_count <= 8'h00;
    end else if (sync_pulse) begin
        sync_count <= sync_count + 8'h01;
    end
end

// ----------------------------------------------------------------
// Channel divider sync control
// ----------------------------------------------------------------
// Both channels see the same pulse so unmasked ones start aligned
aps_chan_sync u_chan_a (
    .core_clk(core_clk),
    .rst(rst),
    .sync_mask(sync_masks[`APS_BIT_MASK_A]),
    .sync_pulse(sync_pulse),
    .hold(hold_a),
    .start(start_a)
);

aps_chan_sync u_chan_b (
    .core_clk(core_clk),
    .rst(rst),
    .sync_mask(sync_masks[`APS_BIT_MASK_B]),
    .sync_pulse(sync_pulse),
    .hold(hold_b),
    .start(start_b)
);

// ----------------------------------------------------------------
// Output registers
// ----------------------------------------------------------------
// Masks drive no driver enable; driver control lives elsewhere
always @(posedge core_clk) begin
    if (rst) begin
        post_vco_divider_ratio <= 4'h0;
        post_vco_divider_ratio_valid <= 1'b0;
        post_vco_divider_reset <= 1'b0;
        loop_filter_bypass <= 1'b0;
        output_channel_a_hold <= 1'b1;
        output_channel_a_start <= 1'b0;
        output_channel_b_hold <= 1'b1;
        output_channel_b_start <= 1'b0;
        sync_armed <= 1'b0;
    end else begin
        post_vco_divider_ratio <= aps_div_ratio(divide_code);
        post_vco_divider_ratio_valid <= (aps_div_ratio(divide_code) != 4'h0);
        post_vco_divider_reset <= div_reset_ctl[`APS_BIT_DIV_RESET];
        loop_filter_bypass <= div_reset_ctl[`APS_BIT_LF_BYPASS];
        output_channel_a_hold <= hold_a;
        output_channel_a_start <= start_a;
        output_channel_b_hold <= hold_b;
        output_channel_b_start <= start_b;
        sync_armed <= armed;
    end
end

// ----------------------------------------------------------------
// Register read
// ----------------------------------------------------------------
// Reserved bits and unmapped addresses read as zero
always @* begin
    next_rdata = 8'h00;
    case (reg_addr)
        `APS_OFS_DIV_RESET_CTL: begin
            next_rdata = {6'h00, div_reset_ctl};
        end
        `APS_OFS_POST_VCO_DIVIDE_RATIO: begin
            next_rdata = {4'h0, divide_code};
        end
        `APS_OFS_DISTRIBUTION_SYNC_CONTROL: begin
            next_rdata = {5'h00, sync_control};
        end
        `APS_OFS_DISTRIBUTION_SYNC_MASKS: begin
            next_rdata = {5'h00, sync_masks};
        end
        `APS_OFS_SYNC_STATUS: begin
            next_rdata = {1'b0, hold_b, hold_a, sync_pending, armed, phase_s, locked_s, cal_done_s};
        end
        `APS_OFS_SYNC_COUNT: begin
            next_rdata = sync_count;
        end
        default: begin
            next_rdata = 8'h00;
        end
    endcase
end

// Read data stands only in the cycle after the strobe
always @(posedge core_clk) begin
    if (rst) begin
        reg_rdata <= 8'h00;
    end else if (reg_rd) begin
        reg_rdata <= next_rdata;
    end else begin
        reg_rdata <= 8'h00;
    end
end

endmodule

// ===== aps_regs.vh
// Register map, field positions, reset values and codes of the
// post-loop-oscillator divider and distribution sync controller.
// Assumes a byte-wide register port with a 12-bit address.
`ifndef APS_REGS_VH
`define APS_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define APS_ADDR_W 12
`define APS_OFS_DIV_RESET_CTL 12'h0433
`define APS_OFS_POST_VCO_DIVIDE_RATIO 12'h0434
`define APS_OFS_DISTRIBUTION_SYNC_CONTROL 12'h0435
`define APS_OFS_DISTRIBUTION_SYNC_MASKS 12'h0436
`define APS_OFS_SYNC_STATUS 12'h0440
`define APS_OFS_SYNC_COMMAND 12'h0441
`define APS_OFS_SYNC_COUNT 12'h0442

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define APS_BIT_LF_BYPASS 0
`define APS_BIT_DIV_RESET 1
`define APS_BIT_SRC_SEL 2
`define APS_BIT_MASK_LOOP 2
`define APS_BIT_MASK_B 1
`define APS_BIT_MASK_A 0
`define APS_BIT_SW_SYNC 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define APS_RST_DIV_RESET_CTL 2'h0
`define APS_RST_DIVIDE_CODE 4'h0
`define APS_RST_SYNC_CONTROL 3'h0
`define APS_RST_SYNC_MASKS 3'h0

// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define APS_AUTO_OFF 2'h0
`define APS_AUTO_FREQ 2'h1
`define APS_AUTO_PHASE 2'h2
`define APS_AUTO_RSVD 2'h3
`define APS_DIV_CODE_TWO 4'h2
`define APS_DIV_CODE_FOUR 4'h4
`define APS_DIV_CODE_MAX 4'hB

`endif

// ===== aps_sync2.v
// Two-stage synchroniser for a group of level inputs from pins.
// Assumes inputs are quasi-static or slower than the core clock.
`timescale 1ns/10ps

module aps_sync2 #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Asynchronous levels in, synchronised levels out
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta;

// ----------------------------------------------------------------
// Two flops; first stage feeds only the second
// ----------------------------------------------------------------
always @(posedge core_clk) begin
    if (rst) begin
        meta <= {WIDTH{1'b0}};
        sync_out <= {WIDTH{1'b0}};
    end else begin
        meta <= async_in;
        sync_out <= meta;
    end
end

endmodule

// ===== aps_chan_sync.v
// Static-sync control for one distribution channel divider.
// Assumes sync_pulse is a one-cycle pulse on the core clock.
`timescale 1ns/10ps

module aps_chan_sync (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Control
    input wire sync_mask,
    input wire sync_pulse,
    // Channel divider control
    output reg hold,
    output reg start
);

reg mask_prev;

// Remember the mask so that clearing it can restore the hold
always @(posedge core_clk) begin
    if (rst) begin
        mask_prev <= 1'b0;
    end else begin
        mask_prev <= sync_mask;
    end
end

// ----------------------------------------------------------------
// Hold until an armed sync, masked channel runs free
// ----------------------------------------------------------------
always @(posedge core_clk) begin
    if (rst) begin
        hold <= 1'b1;
        start <= 1'b0;
    end else if (sync_mask) begin
        hold <= 1'b0;
        start <= 1'b0; // Masked channel ignores sync
    end else if (sync_pulse) begin
        hold <= 1'b0;
        start <= 1'b1; // Restart from programmed phase
    end else begin
        hold <= hold | mask_prev; // Unmasked again: back to static sync
        start <= 1'b0;
    end
end

endmodule

// ===== aps_ctrl_chk.sv
// Concurrent checks on the divider and distribution sync controller.
// Assumes binding to aps_ctrl; sees only its ports.
`timescale 1ns/10ps

module aps_ctrl_chk (
    // Clock, reset and register port
    input wire core_clk,
    input wire rst,
    input wire [11:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    // Divider and channel outputs
    input wire [3:0] post_vco_divider_ratio,
    input wire post_vco_divider_ratio_valid,
    input wire post_vco_divider_reset,
    input wire loop_filter_bypass,
    input wire output_channel_a_hold,
    input wire output_channel_a_start,
    input wire output_channel_b_hold,
    input wire output_channel_b_start,
    input wire sync_armed
);
    // ----------------------------------------------------------------
    // Divider control
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Figures assume no second write to the same place within three cycles
    property p_ratio;
        logic [3:0] c;
        (reg_wr && reg_addr == 12'h434, c = reg_wdata[3:0]) |-> ##3
            {post_vco_divider_ratio_valid, post_vco_divider_ratio} ==
            ((c == 2 || c == 3 || (c >= 5 && c <= 11)) ? {1'b1, c} : 5'h00);
    endproperty
    property p_dreg;
        logic [1:0] d;
        (reg_wr && reg_addr == 12'h433, d = reg_wdata[1:0]) |-> ##3 {post_vco_divider_reset, loop_filter_bypass} == d;
    endproperty

    ratio_decode_a: assert property (p_ratio)
        else $error("divide ratio does not follow the written code");
    div_reset_a: assert property (p_dreg)
        else $error("divider reset level does not follow its bit");
    reset_state_a: assert property (disable iff (1'b0) rst |=> output_channel_a_hold && output_channel_b_hold
        && !output_channel_a_start && !output_channel_b_start && !sync_armed && !post_vco_divider_reset)
        else $error("outputs not at reset state");

    // ----------------------------------------------------------------
    // Channel sync
    // ----------------------------------------------------------------
    mask_a_rel_a: assert property (reg_wr && reg_addr == 12'h436 && reg_wdata[0] |-> ##4 !output_channel_a_hold)
        else $error("channel a not released by its mask");
    mask_b_rel_a: assert property (reg_wr && reg_addr == 12'h436 && reg_wdata[1] |-> ##4 !output_channel_b_hold)
        else $error("channel b not released by its mask");
    start_a_a: assert property (output_channel_a_start |-> !output_channel_a_hold && $past(output_channel_a_hold))
        else $error("channel a started without holding");
    start_b_a: assert property (output_channel_b_start |-> !output_channel_b_hold && $past(output_channel_b_hold))
        else $error("channel b started without holding");
    start_aligned_a: assert property (output_channel_a_start && $past(output_channel_b_hold)
        |-> output_channel_b_start) else $error("held channels did not start together");
    armed_gate_a: assert property (!sync_armed [*6] |=> !output_channel_a_start && !output_channel_b_start)
        else $error("sync issued while not armed");

    // Main scenarios reached
    both_start_c: cover property (output_channel_a_start && output_channel_b_start);
    one_start_c: cover property (output_channel_a_start && !output_channel_b_start);
    armed_rise_c: cover property ($rose(sync_armed));
endmodule

bind aps_ctrl aps_ctrl_chk i_chk (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .post_vco_divider_ratio(post_vco_divider_ratio),
    .post_vco_divider_ratio_valid(post_vco_divider_ratio_valid), .post_vco_divider_reset(post_vco_divider_reset),
    .loop_filter_bypass(loop_filter_bypass), .output_channel_a_hold(output_channel_a_hold),
    .output_channel_a_start(output_channel_a_start), .output_channel_b_hold(output_channel_b_hold),
    .output_channel_b_start(output_channel_b_start), .sync_armed(sync_armed));

// ===== testbench.sv
// Self-checking bench for the divider and distribution sync controller.
// Assumes aps_ctrl with its checker bound; the bench drives every pin.
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module testbench;
    logic core_clk, rst, reg_wr, reg_rd, cal, lck, fl, pl, aref, ext;
    logic [11:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [3:0] ratio;
    logic ratio_ok, div_rst, bypass, a_hold, a_start, b_hold, b_start, armed;
    int mismatches = 0, compares = 0, cyc = 0, nsync = 0;
    logic [7:0] mdl [int];

    aps_ctrl i_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .loop_cal_done(cal), .loop_locked(lck), .digital_tracking_loop_freq_lock(fl),
        .digital_tracking_loop_phase_lock(pl), .active_ref(aref), .ext_sync_req(ext), .post_vco_divider_ratio(ratio),
        .post_vco_divider_ratio_valid(ratio_ok), .post_vco_divider_reset(div_rst), .loop_filter_bypass(bypass),
        .output_channel_a_hold(a_hold), .output_channel_a_start(a_start), .output_channel_b_hold(b_hold),
        .output_channel_b_start(b_start), .sync_armed(armed));

    // ----------------------------------------------------------------
    // Clock, timeout and closing report
    // ----------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Whole run needs about 700 cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("counts: compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Register port tasks and model
    // ----------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        // Reserved bits and command places read back as zero
        mdl[a] = d & (a == 12'h433 ? 8'h03 : a == 12'h434 ? 8'h0f : a inside {12'h435, 12'h436} ? 8'h07 : 8'h00);
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, mdl.exists(a) ? mdl[a] : 8'h00)
    endtask

    function automatic logic [4:0] exp_ratio(input int c);
        return (c == 2 || c == 3 || (c >= 5 && c <= 11)) ? {1'b1, 4'(c)} : 5'h00;
    endfunction

    // Watch a window for start pulses; at most one merged sync expected
    task automatic sync_wait(input int lim, input logic [1:0] e);
        logic [1:0] s;
        s = 2'b00;
        repeat (lim) begin
            @(posedge core_clk);
            #1;
            if (s == 2'b00)
                s = {a_start, b_start};
        end
        if (e != 2'b00)
            nsync++;
        mdl[12'h442] = 8'(nsync);
        `CHK(s, e)
        `CHK({a_hold, b_hold} & e, 2'b00)
    endtask

    // Set then clear both masks so both channels hold again
    task automatic rehold();
        wr(12'h436, 8'h03);
        wr(12'h436, 8'h00);
        repeat (5) @(posedge core_clk);
        #1;
        `CHK({a_hold, b_hold}, 2'b11)
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst, reg_wr, reg_rd, cal, lck, fl, pl, aref, ext} = 9'h100;
        reg_addr = 12'h000;
        reg_wdata = 8'h00;
        void'($urandom(32'hfe0a));
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        // Reset values, an unmapped read, no sync while unarmed
        mdl.delete();
        rd(12'h433);
        rd(12'h434);
        rd(12'h435);
        rd(12'h436);
        rd(12'h7ff);
        `CHK({a_hold, b_hold, armed, ratio_ok}, 4'b1100)
        sync_wait(30, 2'b00);
        $display("test reset done");
        // Every divide code; code 2 taken as legal for a slow oscillator
        for (int c = 0; c < 16; c++) begin
            wr(12'h434, {4'($urandom), 4'(c)});
            repeat (4) @(posedge core_clk);
            #1;
            `CHK({ratio_ok, ratio}, exp_ratio(c))
            rd(12'h434);
        end
        // Divider reset pulse after the ratio changes
        for (int i = 0; i < 4; i++) begin
            wr(12'h433, 8'($urandom) | (i == 0 ? 8'h02 : 8'h00));
            repeat (4) @(posedge core_clk);
            #1;
            `CHK({div_rst, bypass}, mdl[12'h433][1:0])
            rd(12'h433);
        end
        wr(12'h433, 8'h00);
        $display("test divider done");
        // Pending sync from reset waits for calibration and lock
        @(posedge core_clk);
        cal <= 1'b1;
        sync_wait(20, 2'b00);
        @(posedge core_clk);
        lck <= 1'b1;
        sync_wait(20, 2'b11);
        `CHK(armed, 1'b1)
        $display("test arming done");
        // Channel masks: release and ignore sync events
        rehold();
        wr(12'h436, 8'h02);
        repeat (5) @(posedge core_clk);
        #1;
        `CHK({a_hold, b_hold}, 2'b10)
        @(posedge core_clk);
        ext <= 1'b1;
        sync_wait(20, 2'b10);
        @(posedge core_clk);
        ext <= 1'b0;
        rehold();
        wr(12'h436, 8'h01);
        repeat (5) @(posedge core_clk);
        #1;
        `CHK({a_hold, b_hold}, 2'b01)
        wr(12'h441, 8'h01);
        sync_wait(20, 2'b01);
        $display("test masks done");
        // Every automatic sync code against each lock kind
        for (int m = 0; m < 4; m++) begin
            @(posedge core_clk);
            {fl, pl} <= 2'b00;
            rehold();
            wr(12'h435, 8'(m));
            rd(12'h435);
            @(posedge core_clk);
            fl <= 1'b1;
            sync_wait(20, m == 1 ? 2'b11 : 2'b00);
            @(posedge core_clk);
            pl <= 1'b1;
            sync_wait(20, m == 2 ? 2'b11 : 2'b00);
        end
        $display("test auto sync done");
        // Reference-aligned source waits for a rising reference edge
        rehold();
        wr(12'h435, 8'h04);
        wr(12'h441, 8'h01);
        sync_wait(15, 2'b00);
        @(posedge core_clk);
        aref <= 1'b1;
        sync_wait(12, 2'b11);
        @(posedge core_clk);
        aref <= 1'b0;
        $display("test source done");
        // Lock lost: sync withheld until the loop mask overrides it
        wr(12'h435, 8'h00);
        @(posedge core_clk);
        lck <= 1'b0;
        rehold();
        `CHK(armed, 1'b0)
        wr(12'h441, 8'h01);
        sync_wait(20, 2'b00);
        wr(12'h436, 8'h04);
        sync_wait(20, 2'b11);
        rd(12'h436);
        rd(12'h442);
        $display("test loop mask done");
        stop_test();
    end
endmodule
